//--- rtl/dd_regs.svh
// Register offsets, field positions and timing figures of the door driver output control bank.
// Assumes inclusion by bare name from design files under rtl/.
`ifndef DD_REGS_SVH
`define DD_REGS_SVH

// ****************************************
// Offsets
// ****************************************
`define DD_ADDR_W 6
`define DD_DATA_W 16
`define DD_ADDR_BRIDGE_CTRL 6'h00
`define DD_ADDR_LAMP_CTRL 6'h01

// ****************************************
// Field positions and masks
// ****************************************
`define DD_BRIDGE_CTRL_RESET 16'h0000
`define DD_LAMP_CTRL_RESET 16'h0000
`define DD_BRIDGE_CTRL_WMASK 16'hFFF1
`define DD_LAMP_CTRL_WMASK 16'hFFFE
`define DD_MODE_BIT 0
`define DD_BRIDGE_FIRST_HI_BIT 15
`define DD_BRIDGE_PIN_B_IDX 4
`define DD_LAMP7_HI_BIT 15
`define DD_LAMP7_LO_BIT 14
`define DD_LAMP8_HI_BIT 13
`define DD_LAMP8_LO_BIT 12
`define DD_LAMP9_BIT 11
`define DD_LAMP10_BIT 10
`define DD_LAMP11_BIT 9
`define DD_PULLDOWN_BIT 8
`define DD_DAC_MSB 7
`define DD_DAC_LSB 2
`define DD_MIRROR_EN_BIT 1

// ****************************************
// Mirror reference and timing
// ****************************************
`define DD_DAC_ZERO 6'h00
`define DD_DAC_CLAMP_CODE 6'h33
`define DD_CLK_PERIOD_NS 8
`define DD_SETTLE_TIME_NS 50000
`define DD_TIMER_W 20

`endif

//--- rtl/dd_pkg.sv
// Types shared by the door driver output control bank.
// Assumes nothing beyond a SystemVerilog compiler.
package dd_pkg;

  // Gray coded along standby, settling, active
  typedef enum logic [1:0] {
    DD_STANDBY  = 2'b00,
    DD_SETTLING = 2'b01,
    DD_ACTIVE   = 2'b11
  } dd_state_type;

endpackage

//--- rtl/dd_half_bridge.sv
// One half-bridge switch decoder with PWM gating and cross-conduction lockout.
// Assumes synchronised PWM input and a same-clock allow level.
module dd_half_bridge (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic allow,
  input wire logic high_req,
  input wire logic low_req,
  input wire logic pwm_en,
  input wire logic pwm_level,
  output logic high_on,
  output logic low_on
);

  logic gate;

  assign gate = ~pwm_en | pwm_level;

  // [RULE5] exclusive switch decode
  // [RULE6] PWM gated drive
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      high_on <= 1'b0;
      low_on <= 1'b0;
    end else begin
      high_on <= allow & gate & high_req & ~low_req;
      low_on <= allow & gate & low_req & ~high_req;
    end
  end

endmodule

//--- rtl/dd_settle_timer.sv
// Settling timer that runs a fixed count after a start pulse.
// Assumes start is a one-cycle pulse and abort returns it to idle.
`include "dd_regs.svh"

module dd_settle_timer #(
  parameter int unsigned CYCLES = 1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic abort,
  output logic busy
);

  logic [`DD_TIMER_W-1:0] count_q;

  always_ff @(posedge core_clk) begin
    if (!rst_n || abort) begin
      count_q <= '0;
      busy <= 1'b0;
    end else if (start) begin
      count_q <= `DD_TIMER_W'(CYCLES);
      busy <= 1'b1;
    end else if (count_q > `DD_TIMER_W'(1)) begin
      count_q <= count_q - `DD_TIMER_W'(1);
    end else begin
      count_q <= '0;
      busy <= 1'b0;
    end
  end

endmodule

//--- rtl/dd_output_ctrl.sv
// Door driver output control bank: mode and output registers, drive decode, summary flags.
// Assumes a same-clock register port from the serial front end; fault and PWM pins are asynchronous.
//
// What this block does
// [RULE1] Supply/overcurrent summary ORs voltage and overcurrent faults
// [RULE2] Underload summary ORs underloads unless masked
// [RULE3] First bridge underloads can be masked alone
// [RULE4] Standby-to-active sets not-ready until settled
// [RULE5] Bridge bit pairs decode, never both switches
// [RULE6] Bridge PWM enable gates output by pin
// [RULE7] Mode bit selects standby or active
// [RULE8] Clearing mode clears registers, outputs off
// [RULE9] Host waits before re-requesting active mode
// [RULE10] Lamp fields decode LED, bulb, enables
// [RULE11] Lamp PWM enable gates by pin/internal
// [RULE12] Pull-down only when enabled and code zero
// [RULE13] Pull-down PWM enable gates by pin A
// [RULE14] Six-bit mirror reference code, default zero
// [RULE15] Reference clamped to 1.2 V unless full-scale
// [RULE16] Mirror enable drives pass, forces lamp ten
// [RULE17] Bridge five uses pin B, others A
// [RULE18] Full-scale reference spans code times 1.5/64
// [RULE19] Unused control bits read zero, ignore writes
// [RULE20] All control bits reset to zero
`include "dd_regs.svh"

module dd_output_ctrl #(
  parameter int unsigned SETTLE_CYCLES =
    (`DD_SETTLE_TIME_NS + `DD_CLK_PERIOD_NS - 1) / `DD_CLK_PERIOD_NS
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [`DD_ADDR_W-1:0] reg_addr,
  input wire logic [`DD_DATA_W-1:0] reg_wr_data,
  output logic [`DD_DATA_W-1:0] reg_rd_data,
  input wire logic [5:0] bridge_pwm_en,
  input wire logic [4:0] lamp_pwm_en,
  input wire logic mirror_pulldown_pwm_en,
  input wire logic internal_pwm_select,
  input wire logic internal_pwm_level,
  input wire logic full_scale_range,
  input wire logic underload_mask_bits,
  input wire logic [1:0] first_bridge_underload_mask,
  input wire logic ext_pwm_input_a,
  input wire logic ext_pwm_input_b,
  input wire logic supply_undervoltage,
  input wire logic supply_overvoltage,
  input wire logic [11:0] overcurrent_faults,
  input wire logic [5:0] bridge_high_underload,
  input wire logic [5:0] bridge_low_underload,
  input wire logic [4:0] lamp_underload,
  output logic [5:0] bridge_high_switch_enable,
  output logic [5:0] bridge_low_switch_enable,
  output logic [4:0] lamp_on,
  output logic [1:0] lamp_high_current,
  output logic lamp_output_ten,
  output logic mirror_pulldown_enable,
  output logic mirror_pass_drive,
  output logic [5:0] mirror_ref_code,
  output logic supply_overcurrent_summary,
  output logic underload_summary,
  output logic not_ready_flag,
  output logic active_mode
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int unsigned SYNC_W = 2 + 2 + 12 + 6 + 6 + 5;

  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic pwm_a;
  logic pwm_b;
  logic under_v;
  logic over_v;
  logic [11:0] oc_s;
  logic [5:0] under_hi_s;
  logic [5:0] under_lo_s;
  logic [4:0] under_lamp_s;

  assign pins_raw = {ext_pwm_input_a, ext_pwm_input_b, supply_undervoltage, supply_overvoltage,
                     overcurrent_faults, bridge_high_underload, bridge_low_underload, lamp_underload};

  // First stage feeds only the second stage
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end

  assign {pwm_a, pwm_b, under_v, over_v, oc_s, under_hi_s, under_lo_s, under_lamp_s} = sync2_q;

  // ****************************************
  // Control registers
  // ****************************************
  logic [`DD_DATA_W-1:0] bridge_ctrl_q;
  logic [`DD_DATA_W-1:0] lamp_ctrl_q;
  logic wr_bridge;
  logic wr_lamp;
  logic mode_d;

  assign wr_bridge = reg_wr_en && (reg_addr == `DD_ADDR_BRIDGE_CTRL);
  assign wr_lamp = reg_wr_en && (reg_addr == `DD_ADDR_LAMP_CTRL);
  assign mode_d = reg_wr_data[`DD_MODE_BIT];

  // [RULE20] zero after reset
  // [RULE8] standby write wipes both registers
  // [RULE19] reserved bits masked on write
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bridge_ctrl_q <= `DD_BRIDGE_CTRL_RESET;
    end else if (wr_bridge) begin
      bridge_ctrl_q <= mode_d ? (reg_wr_data & `DD_BRIDGE_CTRL_WMASK) : `DD_BRIDGE_CTRL_RESET;
    end
  end

  // Lamp register only holds content while active; standby keeps it clear
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lamp_ctrl_q <= `DD_LAMP_CTRL_RESET;
    end else if (wr_bridge && !mode_d) begin
      lamp_ctrl_q <= `DD_LAMP_CTRL_RESET;
    end else if (wr_lamp && bridge_ctrl_q[`DD_MODE_BIT]) begin
      lamp_ctrl_q <= reg_wr_data & `DD_LAMP_CTRL_WMASK;
    end
  end

  // Read data registered; unmapped addresses answer zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rd_data <= '0;
    end else if (reg_rd_en) begin
      case (reg_addr)
        `DD_ADDR_BRIDGE_CTRL: reg_rd_data <= bridge_ctrl_q;
        `DD_ADDR_LAMP_CTRL: reg_rd_data <= lamp_ctrl_q;
        default: reg_rd_data <= '0;
      endcase
    end
  end

  // ****************************************
  // Mode sequencing
  // ****************************************
  dd_pkg::dd_state_type state_q;
  dd_pkg::dd_state_type state_d;
  logic mode_q;
  logic settle_start;
  logic settle_busy;
  logic allow;

  assign mode_q = bridge_ctrl_q[`DD_MODE_BIT];
  // [RULE4] timer starts on standby-to-active
  assign settle_start = (state_q == dd_pkg::DD_STANDBY) && mode_q;

  dd_settle_timer #(
    .CYCLES(SETTLE_CYCLES)
  ) u_settle (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .start(settle_start),
    .abort(~mode_q),
    .busy(settle_busy)
  );

  // [RULE7] mode bit steers standby or active
  always_comb begin
    state_d = state_q;
    case (state_q)
      dd_pkg::DD_STANDBY: begin
        if (mode_q) begin
          state_d = dd_pkg::DD_SETTLING;
        end
      end
      dd_pkg::DD_SETTLING: begin
        if (!mode_q) begin
          state_d = dd_pkg::DD_STANDBY;
        end else if (!settle_busy) begin
          state_d = dd_pkg::DD_ACTIVE;
        end
      end
      dd_pkg::DD_ACTIVE: begin
        if (!mode_q) begin
          state_d = dd_pkg::DD_STANDBY;
        end
      end
      default: state_d = dd_pkg::DD_STANDBY;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= dd_pkg::DD_STANDBY;
    end else begin
      state_q <= state_d;
    end
  end

  // [RULE4] flag held through settling, outputs blocked
  assign allow = (state_q == dd_pkg::DD_ACTIVE);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      not_ready_flag <= 1'b0;
      active_mode <= 1'b0;
    end else begin
      not_ready_flag <= (state_d == dd_pkg::DD_SETTLING);
      active_mode <= mode_q;
    end
  end

  // ****************************************
  // Half-bridge outputs
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_bridge
      // [RULE17] bridge five follows pin B
      dd_half_bridge u_hb (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .allow(allow),
        .high_req(bridge_ctrl_q[`DD_BRIDGE_FIRST_HI_BIT - 2 * gi]),
        .low_req(bridge_ctrl_q[`DD_BRIDGE_FIRST_HI_BIT - 1 - 2 * gi]),
        .pwm_en(bridge_pwm_en[gi]),
        .pwm_level((gi == `DD_BRIDGE_PIN_B_IDX) ? pwm_b : pwm_a),
        .high_on(bridge_high_switch_enable[gi]),
        .low_on(bridge_low_switch_enable[gi])
      );
    end
  endgenerate

  // ****************************************
  // Lamp outputs
  // ****************************************
  logic [4:0] lamp_req;
  logic [4:0] lamp_src;
  logic [4:0] lamp_gate;
  logic mirror_en;

  assign mirror_en = lamp_ctrl_q[`DD_MIRROR_EN_BIT];

  // [RULE10] two-bit modes for seven and eight
  assign lamp_req[0] = lamp_ctrl_q[`DD_LAMP7_HI_BIT] ^ lamp_ctrl_q[`DD_LAMP7_LO_BIT];
  assign lamp_req[1] = lamp_ctrl_q[`DD_LAMP8_HI_BIT] ^ lamp_ctrl_q[`DD_LAMP8_LO_BIT];
  assign lamp_req[2] = lamp_ctrl_q[`DD_LAMP9_BIT];
  assign lamp_req[3] = lamp_ctrl_q[`DD_LAMP10_BIT];
  assign lamp_req[4] = lamp_ctrl_q[`DD_LAMP11_BIT];

  // [RULE11] pin per lamp, internal unit for seven to ten
  assign lamp_src[0] = internal_pwm_select ? internal_pwm_level : pwm_a;
  assign lamp_src[1] = internal_pwm_select ? internal_pwm_level : pwm_b;
  assign lamp_src[2] = internal_pwm_select ? internal_pwm_level : pwm_a;
  assign lamp_src[3] = internal_pwm_select ? internal_pwm_level : pwm_b;
  assign lamp_src[4] = pwm_a;
  assign lamp_gate = ~lamp_pwm_en | lamp_src;

  // [RULE16] mirror enable forces lamp ten on
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lamp_on <= '0;
      lamp_high_current <= '0;
    end else begin
      lamp_on <= {5{allow}} & ((lamp_req & lamp_gate) | {1'b0, mirror_en, 3'b000});
      lamp_high_current[0] <= allow & lamp_ctrl_q[`DD_LAMP7_HI_BIT] & ~lamp_ctrl_q[`DD_LAMP7_LO_BIT];
      lamp_high_current[1] <= allow & lamp_ctrl_q[`DD_LAMP8_HI_BIT] & ~lamp_ctrl_q[`DD_LAMP8_LO_BIT];
    end
  end

  assign lamp_output_ten = lamp_on[3];

  // ****************************************
  // Mirror controller
  // ****************************************
  logic [5:0] dac_code;

  // [RULE14] six-bit reference field
  assign dac_code = lamp_ctrl_q[`DD_DAC_MSB:`DD_DAC_LSB];

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mirror_pulldown_enable <= 1'b0;
      mirror_pass_drive <= 1'b0;
      mirror_ref_code <= `DD_DAC_ZERO;
    end else begin
      // [RULE12] pull-down only at code zero
      // [RULE13] pull-down gated by pin A
      mirror_pulldown_enable <= allow & lamp_ctrl_q[`DD_PULLDOWN_BIT] & (dac_code == `DD_DAC_ZERO)
                                & (~mirror_pulldown_pwm_en | pwm_a);
      // [RULE16] pass transistor drive
      mirror_pass_drive <= allow & mirror_en;
      // [RULE15] clamp near 1.2 V in reduced range
      // [RULE18] full range passes code unchanged
      if (!full_scale_range && dac_code > `DD_DAC_CLAMP_CODE) begin
        mirror_ref_code <= `DD_DAC_CLAMP_CODE;
      end else begin
        mirror_ref_code <= dac_code;
      end
    end
  end

  // ****************************************
  // Summary flags
  // ****************************************
  logic [5:0] under_hi_kept;
  logic [5:0] under_lo_kept;

  // [RULE3] first bridge masks act alone
  assign under_hi_kept = under_hi_s & ~{5'b00000, first_bridge_underload_mask[1]};
  assign under_lo_kept = under_lo_s & ~{5'b00000, first_bridge_underload_mask[0]};

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      supply_overcurrent_summary <= 1'b0;
      underload_summary <= 1'b0;
    end else begin
      // [RULE1] voltage and overcurrent OR
      supply_overcurrent_summary <= under_v | over_v | (|oc_s);
      // [RULE2] underload OR with global mask
      underload_summary <= ~underload_mask_bits & ((|under_hi_kept) | (|under_lo_kept) | (|under_lamp_s));
    end
  end

endmodule

//--- verification/dd_output_ctrl_asserts.sv
// Port assertions for the output control bank.
// Assumes binding into dd_output_ctrl by matching port names.
module dd_output_ctrl_asserts #(
  parameter int unsigned SETTLE_CYCLES = 1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reg_rd_en,
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_rd_data,
  input wire logic [5:0] bridge_high_switch_enable,
  input wire logic [5:0] bridge_low_switch_enable,
  input wire logic [4:0] lamp_on,
  input wire logic lamp_output_ten,
  input wire logic mirror_pulldown_enable,
  input wire logic mirror_pass_drive,
  input wire logic [5:0] mirror_ref_code,
  input wire logic not_ready_flag,
  input wire logic active_mode
);
  // ****
  // Properties
  // ****
  default clocking dd_cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  logic [18:0] drives;
  logic [19:0] ready_len_q;
  assign drives = {bridge_high_switch_enable, bridge_low_switch_enable, lamp_on,
    mirror_pulldown_enable, mirror_pass_drive};

  // Cycles the not-ready flag has stood so far
  always_ff @(posedge core_clk) begin
    if (!rst_n || !not_ready_flag) begin
      ready_len_q <= '0;
    end else begin
      ready_len_q <= ready_len_q + 20'h00001;
    end
  end

  AST_NO_SHOOT: assert property (~|(bridge_high_switch_enable & bridge_low_switch_enable))
    else $error("bridge has both switches on");
  AST_RESET_OFF: assert property (!$past(rst_n) |-> drives == 19'h00000 && !active_mode)
    else $error("output on after reset");
  AST_STANDBY_OFF: assert property (!active_mode && !$past(active_mode) |-> drives == 19'h00000)
    else $error("output on in standby");
  AST_NOT_READY_OFF: assert property (not_ready_flag |-> drives == 19'h00000)
    else $error("output on while not ready");
  AST_NOT_READY_SET: assert property ($rose(active_mode) |-> not_ready_flag[*4] ##[1:40] !not_ready_flag)
    else $error("not ready flag timing wrong");
  // Standby during settling cuts the flag short, so only a completed settle is timed
  AST_NOT_READY_LEN: assert property ($fell(not_ready_flag) && active_mode |->
    ready_len_q == 20'(SETTLE_CYCLES + 1))
    else $error("not ready flag length wrong");
  AST_PULLDOWN: assert property (mirror_pulldown_enable |-> mirror_ref_code == 6'h00)
    else $error("pull-down on with nonzero code");
  AST_TEN_FORCED: assert property (mirror_pass_drive |-> lamp_output_ten && active_mode)
    else $error("pass drive without lamp ten");
  AST_RD_RSVD: assert property ($past(reg_rd_en) |->
    (reg_rd_data & ($past(reg_addr) == 6'h00 ? 16'h000E : $past(reg_addr) == 6'h01 ? 16'h0001 : 16'hFFFF))
    == 16'h0000)
    else $error("reserved read bits set");
endmodule

bind dd_output_ctrl dd_output_ctrl_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES)) dd_output_ctrl_asserts_i (.*);

//--- verification/dd_host_model.sv
// Host model issuing register writes and reads on the strobe port.
// Assumes tasks are called from one process, off or on the rising edge.
module dd_host_model #(
  parameter int unsigned REACT_CYCLES = 16
) (
  input wire logic core_clk,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [5:0] reg_addr,
  output logic [15:0] reg_wr_data,
  input wire logic [15:0] reg_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic went_standby;
  initial begin
    {reg_wr_en, reg_rd_en, reg_addr, reg_wr_data} = {2'h0, 6'h3F, 16'h5A5A};
    went_standby = 1'b0;
  end
  // ****
  // Access tasks
  // ****
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    if (a == 6'h00 && d[0] && went_standby) repeat (REACT_CYCLES) @(posedge core_clk);
    went_standby = (a == 6'h00) ? !d[0] : went_standby;
    @(posedge core_clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
    // Idle bus shows junk, not the last value
    reg_addr <= ~a;
    reg_wr_data <= ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd_en <= 1'b0;
    reg_addr <= ~a;
    @(negedge core_clk);
    d = reg_rd_data;
  endtask
endmodule

//--- verification/dd_output_ctrl_tb.sv
// Self-checking bench for the output control bank.
// Assumes rtl/ compiled first; the host model owns the register port.
module dd_output_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr_en, reg_rd_en, mirror_pulldown_pwm_en, internal_pwm_select, internal_pwm_level;
  logic full_scale_range, underload_mask_bits, ext_pwm_input_a, ext_pwm_input_b;
  logic supply_undervoltage, supply_overvoltage, lamp_output_ten, mirror_pulldown_enable, mirror_pass_drive;
  logic supply_overcurrent_summary, underload_summary, not_ready_flag, active_mode;
  logic [5:0] reg_addr, bridge_pwm_en, bridge_high_underload, bridge_low_underload, mirror_ref_code;
  logic [5:0] bridge_high_switch_enable, bridge_low_switch_enable;
  logic [15:0] reg_wr_data, reg_rd_data;
  logic [11:0] overcurrent_faults;
  logic [4:0] lamp_pwm_en, lamp_underload, lamp_on;
  logic [1:0] first_bridge_underload_mask, lamp_high_current;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;

  dd_output_ctrl #(.SETTLE_CYCLES(8)) dd_output_ctrl_i (.*);
  dd_host_model #(.REACT_CYCLES(16)) dd_host_model_i (.*);

  always #4 core_clk = ~core_clk;

  // ****
  // Helpers
  // ****
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    if (n_fail == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    dd_host_model_i.wr(a, d);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [15:0] e);
    logic [15:0] v;
    dd_host_model_i.rd(a, v);
    chk(v, e);
  endtask

  // Hang guard, well above the few hundred cycles needed
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      end_sim();
    end
  end

  // ****
  // Sequence
  // ****
  initial begin
    {bridge_pwm_en, lamp_pwm_en, mirror_pulldown_pwm_en, internal_pwm_select, internal_pwm_level,
      full_scale_range, underload_mask_bits, first_bridge_underload_mask, ext_pwm_input_a, ext_pwm_input_b,
      supply_undervoltage, supply_overvoltage, overcurrent_faults, bridge_high_underload,
      bridge_low_underload, lamp_underload} <= '0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    rdc(6'h00, 16'h0000);
    rdc(6'h01, 16'h0000);
    wr(6'h01, 16'h6A00);
    rdc(6'h01, 16'h0000);
    wr(6'h00, 16'h0001);
    w(3);
    chk(16'({active_mode, not_ready_flag}), 16'h0003);
    w(20);
    chk(16'(not_ready_flag), 16'h0000);
    wr(6'h05, 16'hFFFF);
    rdc(6'h05, 16'h0000);
    wr(6'h00, 16'hFFFF);
    rdc(6'h00, 16'hFFF1);
    chk(16'({bridge_high_switch_enable, bridge_low_switch_enable}), 16'h0000);
    wr(6'h00, 16'h9991);
    w(3);
    chk(16'({bridge_high_switch_enable, bridge_low_switch_enable}), 16'h056A);
    @(posedge core_clk);
    bridge_pwm_en <= 6'h3F;
    ext_pwm_input_b <= 1'b1;
    w(5);
    chk(16'({bridge_high_switch_enable, bridge_low_switch_enable}), 16'h0400);
    @(posedge core_clk);
    ext_pwm_input_a <= 1'b1;
    ext_pwm_input_b <= 1'b0;
    w(5);
    chk(16'({bridge_high_switch_enable, bridge_low_switch_enable}), 16'h016A);
    wr(6'h01, 16'h6A01);
    rdc(6'h01, 16'h6A00);
    chk(16'({lamp_high_current, lamp_on}), 16'h0057);
    @(posedge core_clk);
    lamp_pwm_en <= 5'h1F;
    {internal_pwm_select, internal_pwm_level, ext_pwm_input_a} <= 3'h6;
    w(5);
    chk(16'(lamp_on), 16'h0007);
    @(posedge core_clk);
    internal_pwm_select <= 1'b0;
    w(5);
    chk(16'(lamp_on), 16'h0000);
    @(posedge core_clk);
    lamp_pwm_en <= 5'h00;
    mirror_pulldown_pwm_en <= 1'b1;
    wr(6'h01, 16'hC102);
    w(5);
    chk(16'({mirror_pulldown_enable, mirror_pass_drive, lamp_output_ten}), 16'h0003);
    chk(16'({lamp_high_current, lamp_on}), 16'h0008);
    @(posedge core_clk);
    ext_pwm_input_a <= 1'b1;
    w(5);
    chk(16'({mirror_pulldown_enable, mirror_pass_drive, lamp_output_ten}), 16'h0007);
    wr(6'h01, 16'h01FE);
    w(3);
    chk(16'({mirror_pulldown_enable, mirror_ref_code}), 16'h0033);
    @(posedge core_clk);
    full_scale_range <= 1'b1;
    w(3);
    chk(16'(mirror_ref_code), 16'h003F);
    for (int k = 0; k < 15; k++) begin
      @(posedge core_clk);
      {supply_undervoltage, supply_overvoltage, overcurrent_faults} <= 14'h0001 << k;
      w(5);
      chk(16'(supply_overcurrent_summary), (k < 14) ? 16'h0001 : 16'h0000);
    end
    @(posedge core_clk);
    bridge_high_underload <= 6'h01;
    first_bridge_underload_mask <= 2'h2;
    w(5);
    chk(16'(underload_summary), 16'h0000);
    @(posedge core_clk);
    lamp_underload <= 5'h10;
    w(5);
    chk(16'(underload_summary), 16'h0001);
    @(posedge core_clk);
    underload_mask_bits <= 1'b1;
    w(5);
    chk(16'(underload_summary), 16'h0000);
    @(posedge core_clk);
    {underload_mask_bits, lamp_underload, bridge_high_underload} <= '0;
    bridge_low_underload <= 6'h01;
    first_bridge_underload_mask <= 2'h1;
    w(5);
    chk(16'(underload_summary), 16'h0000);
    @(posedge core_clk);
    first_bridge_underload_mask <= 2'h2;
    w(5);
    chk(16'(underload_summary), 16'h0001);
    wr(6'h00, 16'h0000);
    w(3);
    rdc(6'h01, 16'h0000);
    chk(16'({active_mode, bridge_high_switch_enable, bridge_low_switch_enable}), 16'h0000);
    chk(16'({lamp_on, lamp_high_current, mirror_pass_drive}), 16'h0000);
    chk(16'({mirror_pulldown_enable, mirror_ref_code}), 16'h0000);
    wr(6'h00, 16'h0001);
    w(3);
    chk(16'(not_ready_flag), 16'h0001);
    // Bridge requests written while settling must wait for the flag to clear
    wr(6'h00, 16'h9991);
    w(1);
    chk(16'({bridge_high_switch_enable, bridge_low_switch_enable}), 16'h0000);
    w(10);
    chk(16'({not_ready_flag, bridge_high_switch_enable, bridge_low_switch_enable}), 16'h016A);
    end_sim();
  end
endmodule
